/* File: inc/t1fr_pkg.sv */
// constants and types for the t1 framer receive/transmit control bank
package t1fr_pkg;
    // register byte addresses on the parallel port
    localparam logic [7:0] T1FR_RX_CTL_ADDR = 8'h2c; // receive_control_two
    localparam logic [7:0] T1FR_TX_CTL_ADDR = 8'h35; // transmit_control_one
    localparam logic [7:0] T1FR_CCR_ADDR = 8'h37; // common control, elastic store bit
    localparam int T1FR_RESE_BIT = 2; // rx_elastic_store_enable position
    // reset values (power-up contents are undefined, so zero is chosen)
    localparam logic [7:0] T1FR_RX_CTL_RST = 8'h00;
    localparam logic [7:0] T1FR_TX_CTL_RST = 8'h00;
    localparam logic [7:0] T1FR_CCR_RST = 8'h00;
    // replacement codes: idle byte and the digital milliwatt sequence, first byte high
    localparam logic [7:0] T1FR_IDLE_CODE = 8'h7f;
    localparam logic [63:0] T1FR_MW_SEQ = 64'h1e0b0b1e9e8b8b9e;
    // byte bit positions, bit 1 is the msb of a channel byte
    localparam int T1FR_BIT2_POS = 6;
    localparam int T1FR_BIT7_POS = 1;
    localparam int T1FR_BIT8_POS = 0;
    // sync pulse widths in bit periods
    localparam logic [1:0] T1FR_SYNC_NORMAL = 2'h1;
    localparam logic [1:0] T1FR_SYNC_WIDE = 2'h2;
    // error counter width
    localparam int T1FR_CNT_W = 16;
    // transmit clock loss: no edge for this long means the clock has stopped
    localparam int T1FR_CLK_NS = 8;
    localparam int T1FR_TX_LINE_CLOCK_LOSS_NS = 2000;
    localparam int T1FR_TX_LINE_CLOCK_LOSS_CYC = T1FR_TX_LINE_CLOCK_LOSS_NS / T1FR_CLK_NS;
    // receive control fields, bit 7 first
    typedef struct packed {
        logic rx_code_select;
        logic rx_zero_byte_interchange_en;
        logic rx_sync_double_wide;
        logic rx_sync_mode;
        logic rx_sync_direction;
        logic rx_yellow_format_select;
        logic fs_error_report_en;
        logic multiframe_counter_function;
    } t1fr_rxctl_type;
    // transmit control fields, bit 7 first
    typedef struct packed {
        logic tx_clock_loss_fallback;
        logic tx_fbit_pass_through;
        logic tx_crc_pass_through;
        logic tx_soft_signaling_en;
        logic global_bit7_stuff;
        logic tx_link_source_select;
        logic tx_blue_alarm;
        logic tx_yellow_alarm;
    } t1fr_txctl_type;
endpackage

/* File: src/t1fr_code_gen.sv */
// replacement code byte generator: idle byte or the eight-byte milliwatt cycle
`timescale 1ns/100ps
module t1fr_code_gen (
    input wire logic clk, // system clock
    input wire logic reset, // async reset, active high
    input wire logic sel, // 0 idle, 1 milliwatt
    input wire logic step, // one pulse per substituted byte
    output logic [7:0] code_q // registered code byte
);
    import t1fr_pkg::*;
    logic [2:0] idx_q; // position in the milliwatt cycle
    logic [2:0] idx_d;
    logic [7:0] code_d;
    logic [5:0] shift_w; // bit offset of the selected byte
    // the cycle restarts whenever idle is selected so a new milliwatt run begins at byte 0
    assign idx_d = !sel ? 3'h0 : (step ? idx_q + 3'h1 : idx_q);
    assign shift_w = {~idx_d, 3'h0};
    assign code_d = sel ? T1FR_MW_SEQ[shift_w +: 8] : T1FR_IDLE_CODE; // [RULE1]
    // index and output registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            idx_q <= 3'h0;
            code_q <= T1FR_IDLE_CODE;
        end else begin
            idx_q <= idx_d;
            code_q <= code_d;
        end
    end
    code_idle_a: assert property (@(posedge clk) disable iff (reset) // [RULE1]
        !sel |=> code_q == T1FR_IDLE_CODE) else $error("idle code not 7f");
    code_first_a: assert property (@(posedge clk) disable iff (reset) // [RULE1]
        !sel ##1 sel && !step |=> code_q == 8'h1e) else $error("milliwatt not from 1e");
endmodule

/* File: src/t1fr_ctrl.sv */
// receive/transmit control registers of one t1 framer and the datapath they steer
// Summary of operation
// [RULE1] code select picks idle or milliwatt code
// [RULE2] bit 6 enables receive zbtsi
// [RULE3] double-wide widens sync in signaling frames
// [RULE4] software clears double-wide for input/multiframe
// [RULE5] output sync marks frames or multiframes
// [RULE6] direction bit: 0 output, 1 input
// [RULE7] software clears direction when store disabled
// [RULE8] yellow format: bit 2 or frame-12 s-bit
// [RULE9] fs report adds fs errors to counter
// [RULE10] counter counts f-bit errors or oos multiframes
// [RULE11] fallback to receive clock on transmit loss
// [RULE12] f bits internal or from serial in
// [RULE13] crc6 internal or sampled from serial in
// [RULE14] software signaling inserted unless channel blocked
// [RULE15] global or per-channel bit 7 stuffing
// [RULE16] link bits from legacy register or controller
// [RULE17] blue alarm sends unframed all ones
// [RULE18] yellow alarm sent in current framing format
// [RULE19] common bit 2 enables receive elastic store
// [RULE20] registers read back, take effect directly
`timescale 1ns/100ps
module t1fr_ctrl (
    input wire logic clk, // 125 mhz system clock
    input wire logic reset, // async reset, active high
    input wire logic cpu_wr, // register write strobe, one cycle
    input wire logic cpu_rd, // register read strobe, one cycle
    input wire logic [7:0] cpu_addr, // register address
    input wire logic [7:0] cpu_wdata, // write data
    output logic [7:0] cpu_rdata_q, // read data, valid cycle after cpu_rd
    output t1fr_pkg::t1fr_rxctl_type rx_ctl_q, // receive control fields
    output t1fr_pkg::t1fr_txctl_type tx_ctl_q, // transmit control fields
    output logic rx_elastic_store_enable_q, // receive elastic store on
    input wire logic rx_bit_strobe, // one pulse per receive bit period
    input wire logic rx_frame_start, // receive frame boundary pulse
    input wire logic rx_mframe_start, // receive multiframe boundary pulse
    input wire logic rx_sig_frame, // current receive frame carries signaling
    input wire logic rx_sync_pin_i, // sync pin level in
    output logic rx_sync_pin_o, // sync pin drive
    output logic rx_sync_pin_oe, // sync pin enable, high while driving
    output logic rx_sync_ext_q, // external sync seen, elastic store path
    input wire logic rx_byte_step, // advance replacement code byte
    output logic [7:0] rx_code_q, // replacement code byte
    output logic rx_zbtsi_en_q, // receive zbtsi processing on
    input wire logic rx_chan_strobe, // a receive channel byte is present
    input wire logic rx_chan_bit2, // bit 2 of that byte
    input wire logic rx_frame_end, // last channel of a frame seen
    input wire logic rx_sbit12_strobe, // s-bit of frame 12 present
    input wire logic rx_sbit12, // its value
    output logic rx_yellow_q, // yellow alarm detected
    input wire logic ft_err, // ft bit error pulse
    input wire logic fs_err, // fs bit error pulse
    input wire logic fbit_err, // framing bit error pulse
    input wire logic mf_oos, // multiframe received out of sync pulse
    output logic [15:0] path_violation_counter_q, // path code violation count
    output logic [15:0] mf_counter_q, // multiframe counter
    input wire logic tx_line_clock, // transmit line clock level
    output logic tx_clk_sel_rx_q, // formatter runs on receive clock
    input wire logic tx_bit_strobe, // one pulse per transmit bit period
    input wire logic tx_esf_mode, // transmit framing is esf
    input wire logic tx_fbit_time, // current bit is an f-bit slot
    input wire logic tx_crc_slot, // f-bit slot carries crc6
    input wire logic tx_link_slot, // f-bit slot carries fdl or fs
    input wire logic int_fbit, // internally generated framing bit
    input wire logic int_crc, // internally computed crc6 bit
    input wire logic tx_serial_in, // transmit serial data level
    input wire logic legacy_link_bit, // next bit of legacy_link_register
    input wire logic hdlc_link_valid, // controller owns the link
    input wire logic hdlc_link_bit, // controller link bit
    input wire logic tx_link_pin, // link pin level
    output logic tx_fbit_q, // chosen f-bit value
    input wire logic tx_chan_strobe, // a transmit channel byte is present
    input wire logic [7:0] tx_chan_byte, // that byte, bit 1 in msb
    input wire logic tx_sig_frame, // transmit frame carries robbed bits
    input wire logic sig_insert_bit, // bit from signaling_insert_regs
    input wire logic chan_sig_block, // channel_select_regs blocks signaling
    input wire logic chan_stuff_sel, // channel_select_regs selects stuffing
    output logic [7:0] tx_chan_out_q, // formatted channel byte
    output logic tx_yellow_fdl_q, // request esf yellow pattern on the link
    input wire logic tx_pos_in, // encoder positive rail
    input wire logic tx_neg_in, // encoder negative rail
    output logic tx_positive_out, // positive bipolar output
    output logic tx_negative_out // negative bipolar output
);
    import t1fr_pkg::*;

    // register decode
    wire rx_sel = cpu_addr == T1FR_RX_CTL_ADDR;
    wire tx_sel = cpu_addr == T1FR_TX_CTL_ADDR;
    wire cc_sel = cpu_addr == T1FR_CCR_ADDR;
    logic [7:0] ccr_q; // common control image, only bit 2 steers here
    // read mux; unmapped addresses answer zero
    wire [7:0] rd_mux = rx_sel ? rx_ctl_q : tx_sel ? tx_ctl_q : cc_sel ? ccr_q : 8'h00;

    // register writes; every bit stores and reads back as written
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rx_ctl_q <= T1FR_RX_CTL_RST;
            tx_ctl_q <= T1FR_TX_CTL_RST;
            ccr_q <= T1FR_CCR_RST;
        end else if (cpu_wr) begin
            if (rx_sel) rx_ctl_q <= cpu_wdata; // [RULE20]
            if (tx_sel) tx_ctl_q <= cpu_wdata; // [RULE20]
            if (cc_sel) ccr_q <= cpu_wdata;
        end
    end

    // read data register, held until the next read
    always_ff @(posedge clk or posedge reset) begin
        if (reset) cpu_rdata_q <= 8'h00;
        else if (cpu_rd) cpu_rdata_q <= rd_mux; // [RULE20]
    end

    // receive side control levels
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rx_elastic_store_enable_q <= 1'b0;
            rx_zbtsi_en_q <= 1'b0;
        end else begin
            rx_elastic_store_enable_q <= ccr_q[T1FR_RESE_BIT]; // [RULE19]
            rx_zbtsi_en_q <= rx_ctl_q.rx_zero_byte_interchange_en; // [RULE2]
        end
    end

    // replacement code source
    t1fr_code_gen u_code (
        .clk(clk),
        .reset(reset),
        .sel(rx_ctl_q.rx_code_select), // [RULE1]
        .step(rx_byte_step),
        .code_q(rx_code_q)
    );

    // sync pin: boundary choice and width
    logic [1:0] sync_cnt_q; // bit periods left in the pulse
    logic [1:0] sync_cnt_d;
    wire sync_out_mode = !rx_ctl_q.rx_sync_direction; // [RULE6]
    // mode only matters when driving; input mode ignores it
    wire sync_edge = rx_ctl_q.rx_sync_mode ? rx_mframe_start : rx_frame_start; // [RULE5]
    // double-wide is assumed clear in input or multiframe use, so no gating is added
    wire [1:0] sync_width = (rx_ctl_q.rx_sync_double_wide && rx_sig_frame) ?
                            T1FR_SYNC_WIDE : T1FR_SYNC_NORMAL; // [RULE3] [RULE4]
    assign sync_cnt_d = (sync_out_mode && sync_edge) ? sync_width :
                        (rx_bit_strobe && sync_cnt_q != 2'h0) ? sync_cnt_q - 2'h1 :
                        sync_cnt_q;
    // input sampling is only honoured with the elastic store on; software keeps them paired
    wire sync_in_ok = rx_ctl_q.rx_sync_direction && rx_elastic_store_enable_q; // [RULE6] [RULE7]

    // sync pin registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sync_cnt_q <= 2'h0;
            rx_sync_pin_o <= 1'b0;
            rx_sync_pin_oe <= 1'b1;
            rx_sync_ext_q <= 1'b0;
        end else begin
            sync_cnt_q <= sync_cnt_d;
            rx_sync_pin_o <= sync_out_mode && sync_cnt_d != 2'h0;
            rx_sync_pin_oe <= sync_out_mode; // [RULE6]
            rx_sync_ext_q <= sync_in_ok && rx_sync_pin_i;
        end
    end

    // yellow detection: all-zero bit 2 over a frame, or frame-12 s-bit
    logic bit2_zero_q; // every channel so far had bit 2 clear
    wire bit2_zero_d = rx_frame_end ? 1'b1 :
                       (rx_chan_strobe ? bit2_zero_q && !rx_chan_bit2 : bit2_zero_q);
    wire frame_verdict = bit2_zero_q && !(rx_chan_strobe && rx_chan_bit2);
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bit2_zero_q <= 1'b1;
            rx_yellow_q <= 1'b0;
        end else begin
            bit2_zero_q <= bit2_zero_d;
            if (rx_ctl_q.rx_yellow_format_select) begin
                if (rx_sbit12_strobe) rx_yellow_q <= rx_sbit12; // [RULE8]
            end else if (rx_frame_end) begin
                rx_yellow_q <= frame_verdict; // [RULE8]
            end
        end
    end

    // error counters, saturating so a long fault never wraps to a small value
    wire pcv_inc = ft_err || (rx_ctl_q.fs_error_report_en && fs_err); // [RULE9]
    wire mf_inc = rx_ctl_q.multiframe_counter_function ? mf_oos : fbit_err; // [RULE10]
    wire pcv_full = &path_violation_counter_q;
    wire mf_full = &mf_counter_q;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            path_violation_counter_q <= '0;
            mf_counter_q <= '0;
        end else begin
            if (pcv_inc && !pcv_full) path_violation_counter_q <= path_violation_counter_q + 16'h1;
            if (mf_inc && !mf_full) mf_counter_q <= mf_counter_q + 16'h1;
        end
    end

    // transmit clock watchdog; the clock is sampled as a level, so it must be slow vs clk
    localparam logic [8:0] LOSS_CNT = 9'(T1FR_TX_LINE_CLOCK_LOSS_CYC);
    logic tx_line_clock_prev_q; // last sampled transmit clock level
    logic [8:0] idle_cnt_q; // cycles since last transmit clock edge
    wire tx_line_clock_edge = tx_line_clock != tx_line_clock_prev_q;
    wire tx_line_clock_lost = idle_cnt_q == LOSS_CNT;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tx_line_clock_prev_q <= 1'b0;
            idle_cnt_q <= 9'h0;
            tx_clk_sel_rx_q <= 1'b0;
        end else begin
            tx_line_clock_prev_q <= tx_line_clock;
            if (tx_line_clock_edge) idle_cnt_q <= 9'h0;
            else if (!tx_line_clock_lost) idle_cnt_q <= idle_cnt_q + 9'h1;
            tx_clk_sel_rx_q <= tx_ctl_q.tx_clock_loss_fallback && tx_line_clock_lost; // [RULE11]
        end
    end

    // f-bit source selection
    wire link_src = tx_ctl_q.tx_link_source_select ?
                    (hdlc_link_valid ? hdlc_link_bit : tx_link_pin) :
                    legacy_link_bit; // [RULE16]
    wire crc_src = tx_ctl_q.tx_crc_pass_through ? tx_serial_in : int_crc; // [RULE13]
    wire fbit_int = tx_crc_slot ? crc_src : (tx_link_slot ? link_src : int_fbit);
    // pass-through takes every f bit from serial in, crc slots included
    wire fbit_sel = tx_ctl_q.tx_fbit_pass_through ? tx_serial_in : fbit_int; // [RULE12]
    always_ff @(posedge clk or posedge reset) begin
        if (reset) tx_fbit_q <= 1'b0;
        else if (tx_fbit_time) tx_fbit_q <= fbit_sel;
    end

    // channel byte formatting: yellow, stuffing, then robbed-bit signaling
    wire d4_yel = tx_ctl_q.tx_yellow_alarm && !tx_esf_mode; // [RULE18]
    logic [7:0] yel_byte; // bit 2 cleared during d4 yellow
    logic [7:0] stuff_byte; // bit 7 forced for all-zero bytes
    logic [7:0] fmt_byte; // signaling applied
    wire stuff_on = tx_ctl_q.global_bit7_stuff || chan_stuff_sel; // [RULE15]
    wire sig_on = tx_ctl_q.tx_soft_signaling_en && !chan_sig_block && tx_sig_frame; // [RULE14]
    always_comb begin
        yel_byte = tx_chan_byte;
        if (d4_yel) yel_byte[T1FR_BIT2_POS] = 1'b0;
        stuff_byte = yel_byte;
        if (stuff_on && yel_byte == 8'h00) stuff_byte[T1FR_BIT7_POS] = 1'b1; // [RULE15]
        fmt_byte = stuff_byte;
        if (sig_on) fmt_byte[T1FR_BIT8_POS] = sig_insert_bit; // [RULE14]
    end

    // formatted byte and esf yellow request
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tx_chan_out_q <= 8'h00;
            tx_yellow_fdl_q <= 1'b0;
        end else begin
            if (tx_chan_strobe) tx_chan_out_q <= fmt_byte;
            tx_yellow_fdl_q <= tx_ctl_q.tx_yellow_alarm && tx_esf_mode; // [RULE18]
        end
    end

    // line outputs; blue alarm alternates marks so the all-ones stays bipolar
    logic blue_rail_q; // next blue mark goes on the negative rail
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            blue_rail_q <= 1'b0;
            tx_positive_out <= 1'b0;
            tx_negative_out <= 1'b0;
        end else if (tx_ctl_q.tx_blue_alarm) begin
            if (tx_bit_strobe) begin
                blue_rail_q <= !blue_rail_q;
                tx_positive_out <= !blue_rail_q; // [RULE17]
                tx_negative_out <= blue_rail_q; // [RULE17]
            end
        end else begin
            tx_positive_out <= tx_pos_in;
            tx_negative_out <= tx_neg_in;
        end
    end

    // checks
    rd_unmapped_a: assert property (@(posedge clk) disable iff (reset) // [RULE20]
        cpu_rd && !rx_sel && !tx_sel && !cc_sel |=> cpu_rdata_q == 8'h00)
        else $error("unmapped read not zero");
    rd_back_a: assert property (@(posedge clk) disable iff (reset) // [RULE20]
        cpu_wr && tx_sel ##1 cpu_rd && !cpu_wr && tx_sel |=> cpu_rdata_q == $past(cpu_wdata, 2))
        else $error("transmit control readback wrong");
    zbtsi_lvl_a: assert property (@(posedge clk) disable iff (reset) // [RULE2]
        rx_ctl_q.rx_zero_byte_interchange_en [*2] |-> rx_zbtsi_en_q)
        else $error("zbtsi not enabled");
    sync_dir_a: assert property (@(posedge clk) disable iff (reset) // [RULE6]
        rx_ctl_q.rx_sync_direction |=> !rx_sync_pin_oe && !rx_sync_pin_o)
        else $error("sync pin driven in input mode");
    sync_wide_a: assert property (@(posedge clk) disable iff (reset) // [RULE3]
        sync_out_mode && !rx_ctl_q.rx_sync_mode && rx_ctl_q.rx_sync_double_wide &&
        rx_frame_start && rx_sig_frame && !rx_bit_strobe |=> sync_cnt_q == T1FR_SYNC_WIDE)
        else $error("double-wide pulse not loaded");
    pcv_hold_a: assert property (@(posedge clk) disable iff (reset) // [RULE9]
        !ft_err && !(rx_ctl_q.fs_error_report_en && fs_err) |=> $stable(path_violation_counter_q))
        else $error("path counter moved without error");
    mf_count_a: assert property (@(posedge clk) disable iff (reset) // [RULE10]
        rx_ctl_q.multiframe_counter_function && mf_oos && !mf_full |=>
        mf_counter_q == $past(mf_counter_q) + 16'h1)
        else $error("oos multiframe not counted");
    clk_fallback_a: assert property (@(posedge clk) disable iff (reset) // [RULE11]
        !tx_ctl_q.tx_clock_loss_fallback |=> !tx_clk_sel_rx_q)
        else $error("clock switched while fallback off");
    fbit_pass_a: assert property (@(posedge clk) disable iff (reset) // [RULE12]
        tx_ctl_q.tx_fbit_pass_through && tx_fbit_time |=> tx_fbit_q == $past(tx_serial_in))
        else $error("f bit not from serial in");
    bit7_stuff_a: assert property (@(posedge clk) disable iff (reset) // [RULE15]
        tx_ctl_q.global_bit7_stuff && tx_chan_strobe && tx_chan_byte == 8'h00 && !sig_on
        |=> tx_chan_out_q == 8'h02)
        else $error("all-zero byte not stuffed");
    blue_mark_a: assert property (@(posedge clk) disable iff (reset) // [RULE17]
        tx_ctl_q.tx_blue_alarm && tx_bit_strobe |=> tx_positive_out != tx_negative_out)
        else $error("blue alarm mark missing");
    blue_cov: cover property (@(posedge clk) disable iff (reset)
        tx_ctl_q.tx_blue_alarm && tx_bit_strobe ##1 tx_bit_strobe);
    fallback_cov: cover property (@(posedge clk) disable iff (reset) $rose(tx_clk_sel_rx_q));
    sync_in_cov: cover property (@(posedge clk) disable iff (reset) $rose(rx_sync_ext_q));
endmodule

/* File: testbench/test_t1_framer_rx_tx_control.sv */
// self-checking bench for the t1 framer receive/transmit control bank
`timescale 1ns/100ps
module test_t1_framer_rx_tx_control;
    import t1fr_pkg::*;
    logic clk = 0, reset = 1, cpu_wr = 0, cpu_rd = 0, line_run = 1; // line_run: tx clock alive
    logic [7:0] cpu_addr = 8'h00, cpu_wdata = 8'h00, tx_chan_byte = 8'h00;
    logic [7:0] cpu_rdata_q, rx_code_q, tx_chan_out_q; // byte outputs
    logic [15:0] path_violation_counter_q, mf_counter_q; // counters
    t1fr_rxctl_type rx_ctl_q;
    t1fr_txctl_type tx_ctl_q;
    logic rx_bit_strobe = 0, rx_frame_start = 0, rx_mframe_start = 0, rx_sig_frame = 0;
    logic rx_sync_pin_i = 0, rx_byte_step = 0, rx_chan_strobe = 0, rx_chan_bit2 = 0;
    logic rx_frame_end = 0, rx_sbit12_strobe = 0, rx_sbit12 = 0, ft_err = 0, fs_err = 0;
    logic fbit_err = 0, mf_oos = 0, tx_line_clock = 0, tx_bit_strobe = 0, tx_esf_mode = 0;
    logic tx_fbit_time = 0, tx_crc_slot = 0, tx_link_slot = 0, int_fbit = 1, int_crc = 1;
    logic tx_serial_in = 0, legacy_link_bit = 1, hdlc_link_valid = 0, hdlc_link_bit = 0;
    logic tx_link_pin = 1, tx_chan_strobe = 0, tx_sig_frame = 0, sig_insert_bit = 0;
    logic chan_sig_block = 0, chan_stuff_sel = 0, tx_pos_in = 0, tx_neg_in = 0;
    logic rx_elastic_store_enable_q, rx_sync_pin_o, rx_sync_pin_oe, rx_sync_ext_q;
    logic rx_zbtsi_en_q, rx_yellow_q, tx_clk_sel_rx_q, tx_fbit_q, tx_yellow_fdl_q;
    logic tx_positive_out, tx_negative_out; // bipolar rails
    int n_fail = 0, check_count = 0, cycles = 0;
    t1fr_ctrl dut (.*);
    // 8 ns system clock
    always #4 clk = ~clk;
    // line clock toggles on the rising edge so stopping it never races the stimulus
    always @(posedge clk) begin
        if (line_run) begin
            tx_line_clock <= ~tx_line_clock;
        end
    end
    // hang guard, well above the roughly 680 cycles the sequence needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_fail++;
            wrap_up();
        end
    end
    task automatic tick(input int n = 1);
        repeat (n) @(negedge clk);
    endtask
    // compare seen against expected, four-state
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // extra tick after release so the same strobe is never set twice in one step
    task automatic pulse(ref logic s);
        s = 1;
        tick();
        s = 0;
        tick();
    endtask
    // idle cycle first so two writes in a row never set the strobe twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        tick();
        cpu_addr = a;
        cpu_wdata = d;
        cpu_wr = 1;
        tick();
        cpu_wr = 0;
    endtask
    // read data lands one cycle after the strobe edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        cpu_addr = a;
        cpu_rd = 1;
        tick();
        cpu_rd = 0;
        chk(cpu_rdata_q, exp);
        tick();
    endtask
    // one framing-bit slot with a chosen source setup
    task automatic fb(input logic [7:0] ctl, input logic [1:0] slot, input logic ser,
                      input logic hv, input logic exp);
        wr(T1FR_TX_CTL_ADDR, ctl);
        {tx_crc_slot, tx_link_slot} = slot;
        tx_serial_in = ser;
        hdlc_link_valid = hv;
        pulse(tx_fbit_time);
        chk(tx_fbit_q, exp);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        tick(8);
        reset = 0;
        // register bank: reset value, readback right after a write, unmapped address
        rd(T1FR_TX_CTL_ADDR, 8'h00);
        // store goes on before input sync is picked; double-wide stays clear meanwhile
        wr(T1FR_CCR_ADDR, 8'h04);
        wr(T1FR_RX_CTL_ADDR, 8'h5a);
        wr(T1FR_TX_CTL_ADDR, 8'ha5);
        rd(T1FR_TX_CTL_ADDR, 8'ha5);
        rd(T1FR_RX_CTL_ADDR, 8'h5a);
        rd(8'h36, 8'h00);
        chk({rx_ctl_q, tx_ctl_q}, 16'h5aa5);
        chk(rx_zbtsi_en_q, 1'h1);
        rx_sync_pin_i = 1;
        tick();
        chk({rx_elastic_store_enable_q, rx_sync_pin_oe, rx_sync_ext_q}, 3'h5);
        wr(T1FR_RX_CTL_ADDR, 8'h00);
        tick();
        chk({rx_zbtsi_en_q, rx_sync_pin_oe, rx_code_q}, {2'h1, 8'h7f});
        // sync output: frame, double-wide, multiframe
        pulse(rx_frame_start);
        chk(rx_sync_pin_o, 1'h1);
        pulse(rx_bit_strobe);
        chk(rx_sync_pin_o, 1'h0);
        wr(T1FR_RX_CTL_ADDR, 8'h20);
        rx_sig_frame = 1;
        pulse(rx_frame_start);
        pulse(rx_bit_strobe);
        chk(rx_sync_pin_o, 1'h1);
        pulse(rx_bit_strobe);
        chk(rx_sync_pin_o, 1'h0);
        wr(T1FR_RX_CTL_ADDR, 8'h10);
        pulse(rx_frame_start);
        chk(rx_sync_pin_o, 1'h0);
        pulse(rx_mframe_start);
        chk(rx_sync_pin_o, 1'h1);
        // milliwatt cycle wraps back to its first byte
        wr(T1FR_RX_CTL_ADDR, 8'h80);
        tick();
        for (int i = 0; i < 9; i++) begin
            chk(rx_code_q, T1FR_MW_SEQ[63 - 8 * (i % 8) -: 8]);
            pulse(rx_byte_step);
        end
        // receive yellow in both formats
        pulse(rx_chan_strobe);
        pulse(rx_frame_end);
        chk(rx_yellow_q, 1'h1);
        rx_chan_bit2 = 1;
        pulse(rx_chan_strobe);
        pulse(rx_frame_end);
        chk(rx_yellow_q, 1'h0);
        wr(T1FR_RX_CTL_ADDR, 8'h04);
        rx_sbit12 = 1;
        pulse(rx_sbit12_strobe);
        chk(rx_yellow_q, 1'h1);
        // error counters under both function selections
        pulse(ft_err);
        pulse(fs_err);
        pulse(fbit_err);
        pulse(mf_oos);
        chk({path_violation_counter_q, mf_counter_q}, {16'h1, 16'h1});
        wr(T1FR_RX_CTL_ADDR, 8'h03);
        pulse(fs_err);
        pulse(fbit_err);
        pulse(mf_oos);
        chk({path_violation_counter_q, mf_counter_q}, {16'h2, 16'h2});
        // channel byte formatting
        wr(T1FR_TX_CTL_ADDR, 8'h08);
        pulse(tx_chan_strobe);
        chk(tx_chan_out_q, 8'h02);
        wr(T1FR_TX_CTL_ADDR, 8'h00);
        pulse(tx_chan_strobe);
        chk(tx_chan_out_q, 8'h00);
        chan_stuff_sel = 1;
        pulse(tx_chan_strobe);
        chk(tx_chan_out_q, 8'h02);
        wr(T1FR_TX_CTL_ADDR, 8'h10);
        tx_chan_byte = 8'hf0;
        tx_sig_frame = 1;
        sig_insert_bit = 1;
        pulse(tx_chan_strobe);
        chk(tx_chan_out_q, 8'hf1);
        chan_sig_block = 1;
        pulse(tx_chan_strobe);
        chk(tx_chan_out_q, 8'hf0);
        wr(T1FR_TX_CTL_ADDR, 8'h01);
        tx_chan_byte = 8'hff;
        pulse(tx_chan_strobe);
        chk(tx_chan_out_q, 8'hbf);
        tx_esf_mode = 1;
        tick();
        chk(tx_yellow_fdl_q, 1'h1);
        // framing bit sources; expected values alternate so a stuck bit shows
        fb(8'h00, 2'h0, 1'h0, 1'h0, 1'h1);
        fb(8'h40, 2'h0, 1'h0, 1'h0, 1'h0);
        fb(8'h00, 2'h2, 1'h0, 1'h0, 1'h1);
        fb(8'h20, 2'h2, 1'h0, 1'h0, 1'h0);
        fb(8'h00, 2'h1, 1'h0, 1'h1, 1'h1);
        fb(8'h04, 2'h1, 1'h1, 1'h1, 1'h0);
        fb(8'h04, 2'h1, 1'h0, 1'h0, 1'h1);
        // blue alarm alternates rails, then normal data passes through
        wr(T1FR_TX_CTL_ADDR, 8'h02);
        pulse(tx_bit_strobe);
        chk({tx_positive_out, tx_negative_out}, 2'h2);
        pulse(tx_bit_strobe);
        chk({tx_positive_out, tx_negative_out}, 2'h1);
        wr(T1FR_TX_CTL_ADDR, 8'h00);
        tx_pos_in = 1;
        tick();
        chk({tx_positive_out, tx_negative_out}, 2'h2);
        // lost line clock: no switch unless fallback is set, release once it returns
        line_run = 0;
        tick(260);
        chk(tx_clk_sel_rx_q, 1'h0);
        line_run = 1;
        wr(T1FR_TX_CTL_ADDR, 8'h80);
        line_run = 0;
        tick(260);
        chk(tx_clk_sel_rx_q, 1'h1);
        line_run = 1;
        tick(4);
        chk(tx_clk_sel_rx_q, 1'h0);
        wrap_up();
    end
endmodule
